// ---- verilog/pio_port_irq.sv ----
// Three 8-bit latched I/O ports with port C and external interrupt sources
`timescale 1ns/1ps
module pio_port_irq
(
  input  wire logic                     clock_i,
  input  wire logic                     rst_i,
  input  wire logic [2:0]               addr_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  input  wire logic [7:0]               wdata_i,
  output logic      [7:0]               rdata_o,
  input  wire logic [pio_pkg::PIN_W-1:0] pin_in_i,
  output logic      [pio_pkg::PIN_W-1:0] pin_out_o,
  output logic      [pio_pkg::PIN_W-1:0] pin_oe_o,
  input  wire logic                     ext_irq_i,
  output logic                          irq_o
);

  localparam int PW = pio_pkg::PORT_W;
  localparam int SW = pio_pkg::PIN_W + 1;

  logic [pio_pkg::PIN_W-1:0]  latch_q;
  logic [pio_pkg::PIN_W-1:0]  oe_q;
  logic [SW-1:0]              sync1_q;
  logic [SW-1:0]              sync2_q;
  logic [PW-1:0]              ien_q;
  logic [pio_pkg::MODE_W-1:0] mode_q;
  logic [7:0]                 rdata_q;
  logic                       irq_q;
  logic [PW:0]                pend;
  logic [PW:0]                cond;
  logic [PW:0]                setv;
  logic [PW:0]                seen;
  logic [PW:0]                ackv;
  logic [PW:0]                env;
  logic                       ack_wr;
  logic                       ext_ack;
  logic                       any_pend;
  logic [PW-1:0]              port_a_rd;
  logic [PW-1:0]              port_b_rd;
  logic [PW-1:0]              port_c_rd;
  logic [7:0]                 rd_mux;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // two-flop synchroniser
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {ext_irq_i, pin_in_i};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Port latches and pin drive
  // ----------------------------------------------------------------
  // Drive is open-collector like: a latched zero sinks, a latched one lets the pin float as an input
  // latch steers direction
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // A latched zero means module on, so reset leaves every channel sinking
      latch_q <= '0;
      oe_q    <= '1;
    end
    else if (wr_i)
    begin
      case (addr_i)
        pio_pkg::OFS_PORT_A:
        begin
          latch_q[0 +: PW] <= wdata_i;
          oe_q[0 +: PW]    <= ~wdata_i;
        end
        pio_pkg::OFS_PORT_B:
        begin
          latch_q[pio_pkg::PORT_B_LSB +: PW] <= wdata_i;
          oe_q[pio_pkg::PORT_B_LSB +: PW]    <= ~wdata_i;
        end
        pio_pkg::OFS_PORT_C:
        begin
          latch_q[pio_pkg::PORT_C_LSB +: PW] <= wdata_i;
          oe_q[pio_pkg::PORT_C_LSB +: PW]    <= ~wdata_i;
        end
        default:
        begin
          latch_q <= latch_q;
          oe_q    <= oe_q;
        end
      endcase
    end
  end

  assign pin_out_o = latch_q;
  assign pin_oe_o  = oe_q;

  // ----------------------------------------------------------------
  // Interrupt configuration
  // ----------------------------------------------------------------
  // enable and mode offsets
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      ien_q <= pio_pkg::BYTE_ZERO;
    else if (wr_i && addr_i == pio_pkg::OFS_IRQ_ENABLE)
      ien_q <= wdata_i;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      mode_q <= '0;
    else if (wr_i && addr_i == pio_pkg::OFS_IRQ_MODE)
      mode_q <= wdata_i[pio_pkg::MODE_W-1:0];
  end

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  // port C acknowledge shares status offset; external acknowledge shares mode offset
  assign ack_wr  = wr_i && addr_i == pio_pkg::OFS_IRQ_STATUS;
  assign ext_ack = wr_i && addr_i == pio_pkg::OFS_IRQ_MODE && wdata_i[pio_pkg::EXT_PEND_B];

  genvar gi;
  generate
    for (gi = 0; gi <= PW; gi++)
    begin : g_src
      logic [1:0] sel;
      if (gi == PW)
      begin : g_ext
        assign env[gi]  = mode_q[pio_pkg::EXT_EN_B];
        assign ackv[gi] = ext_ack;
        assign sel      = mode_q[pio_pkg::EXT_SEL_LSB +: 2];
      end
      else
      begin : g_portc
        // A port C line only senses when latched as input and enabled
        assign env[gi]  = ien_q[gi] & latch_q[pio_pkg::PORT_C_LSB + gi];
        assign ackv[gi] = ack_wr & wdata_i[gi];
        assign sel      = (gi < pio_pkg::NIBBLE_W) ? mode_q[pio_pkg::LO_SEL_LSB +: 2]
                                                   : mode_q[pio_pkg::HI_SEL_LSB +: 2];
      end
      pio_irq_cell u_cell
      (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .level_i    (sync2_q[(gi == PW) ? pio_pkg::EXT_BIT : pio_pkg::PORT_C_LSB + gi]),
        .enable_i   (env[gi]),
        .mode_i     (sel),
        .ack_i      (ackv[gi]),
        .cond_o     (cond[gi]),
        .set_o      (setv[gi]),
        .ack_seen_o (seen[gi]),
        .pending_o  (pend[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Host request
  // ----------------------------------------------------------------
  assign any_pend = |pend;

  // The request drops for one cycle after each acknowledge so the host sees a new edge
  // nonzero status requests
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      irq_q <= 1'b0;
    else
      irq_q <= any_pend && !(ack_wr || ext_ack);
  end

  assign irq_o = irq_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // unlatched channels read zero
  assign port_a_rd = latch_q[0 +: PW] & sync2_q[0 +: PW];
  assign port_b_rd = latch_q[pio_pkg::PORT_B_LSB +: PW] & sync2_q[pio_pkg::PORT_B_LSB +: PW];
  assign port_c_rd = latch_q[pio_pkg::PORT_C_LSB +: PW] & sync2_q[pio_pkg::PORT_C_LSB +: PW];

  always_comb
  begin
    case (addr_i)
      pio_pkg::OFS_PORT_A:     rd_mux = port_a_rd;
      pio_pkg::OFS_PORT_B:     rd_mux = port_b_rd;
      pio_pkg::OFS_PORT_C:     rd_mux = port_c_rd;
      pio_pkg::OFS_IRQ_ENABLE: rd_mux = ien_q;
      pio_pkg::OFS_IRQ_MODE:   rd_mux = {pend[PW], mode_q};
      pio_pkg::OFS_IRQ_STATUS: rd_mux = pend[PW-1:0];
      default:                 rd_mux = pio_pkg::BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_q <= pio_pkg::BYTE_ZERO;
    else if (rd_i)
      rdata_q <= rd_mux;
  end

  assign rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ACK_CLEARS: assert property (@(posedge clock_i) disable iff (rst_i)
    ack_wr |=> ((pend[PW-1:0] & $past(wdata_i & pend[PW-1:0] & ~cond[PW-1:0])) == pio_pkg::BYTE_ZERO))
    else $error("Acknowledged status with no cause did not clear");

  AST_HOLD_UNACKED: assert property (@(posedge clock_i) disable iff (rst_i)
    ((($past(pend) & ~pend) & ~$past(ackv | seen)) == '0))
    else $error("Status cleared without acknowledge");

  AST_CAUSE_HOLDS: assert property (@(posedge clock_i) disable iff (rst_i)
    ((($past(pend) & ~pend) & $past(cond)) == '0))
    else $error("Status cleared while cause present");

  AST_SET_PENDS: assert property (@(posedge clock_i) disable iff (rst_i)
    ((pend & $past(setv)) == $past(setv)))
    else $error("Detected event did not leave status set");

  AST_REQ_LEVEL: assert property (@(posedge clock_i) disable iff (rst_i)
    (pend[PW-1:0] != pio_pkg::BYTE_ZERO && !ack_wr && !ext_ack) |=> irq_o)
    else $error("Request missing while status nonzero");

  AST_FRESH_REQ: assert property (@(posedge clock_i) disable iff (rst_i)
    (ack_wr ##1 (any_pend && !ack_wr && !ext_ack)) |=> (irq_o && !$past(irq_o)))
    else $error("No fresh request after acknowledge");

  AST_EXT_REQ: assert property (@(posedge clock_i) disable iff (rst_i)
    (pend[PW] && !ack_wr && !ext_ack) |=> irq_o)
    else $error("External pending gave no request");

  AST_MASKED_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    (rd_i && addr_i == pio_pkg::OFS_PORT_A) |=> ((rdata_o & ~latch_q[0 +: PW]) == pio_pkg::BYTE_ZERO))
    else $error("Masked channel read as one");

  AST_DRIVE: assert property (@(posedge clock_i) disable iff (rst_i)
    pin_oe_o == ~pin_out_o)
    else $error("Output enable disagrees with latch");

  AST_RESET_CLEAR: assert property (@(posedge clock_i)
    $fell(rst_i) |-> (latch_q == '0 && ien_q == pio_pkg::BYTE_ZERO && pend == '0 && !irq_o))
    else $error("State not cleared by reset");

  COV_PORTC_IRQ: cover property (@(posedge clock_i) disable iff (rst_i) $rose(pend[0]) ##[1:20] ack_wr);
  COV_EXT_IRQ:   cover property (@(posedge clock_i) disable iff (rst_i) $rose(pend[PW]) ##[1:20] ext_ack);
  COV_REFIRE:    cover property (@(posedge clock_i) disable iff (rst_i) ack_wr ##1 !irq_o ##1 irq_o);

endmodule

// ---- verilog/pio_pkg.sv ----
// Register map, field positions and interrupt sense encodings of the parallel I/O block
package pio_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_PORT_A     = 3'h0;
  localparam logic [2:0] OFS_PORT_B     = 3'h1;
  localparam logic [2:0] OFS_PORT_C     = 3'h2;
  localparam logic [2:0] OFS_IRQ_ENABLE = 3'h5;
  localparam logic [2:0] OFS_IRQ_MODE   = 3'h6;
  localparam logic [2:0] OFS_IRQ_STATUS = 3'h7;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int PORT_W      = 8;
  localparam int NUM_PORTS   = 3;
  localparam int PIN_W       = PORT_W * NUM_PORTS;
  localparam int PORT_B_LSB  = 8;
  localparam int PORT_C_LSB  = 16;
  localparam int EXT_BIT     = PIN_W;
  localparam int NIBBLE_W    = 4;
  localparam int MODE_W      = 7;
  localparam int EXT_PEND_B  = 7;
  localparam int EXT_EN_B    = 6;
  localparam int EXT_SEL_LSB = 4;
  localparam int HI_SEL_LSB  = 2;
  localparam int LO_SEL_LSB  = 0;

  // ----------------------------------------------------------------
  // Reset values and sense encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_HIGH = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

endpackage

// ---- verilog/pio_irq_cell.sv ----
// One interrupt source: level or edge sensing, pending flag, acknowledge-then-clear
`timescale 1ns/1ps
module pio_irq_cell
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       level_i,
  input  wire logic       enable_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       ack_i,
  output logic            cond_o,
  output logic            set_o,
  output logic            ack_seen_o,
  output logic            pending_o
);

  logic prev_q;
  logic pending_q;
  logic ack_seen_q;
  logic raw_cond;
  logic clr;
  logic edge_mode;

  // ----------------------------------------------------------------
  // Condition detection
  // ----------------------------------------------------------------
  // shared sense encoding
  always_comb
  begin
    case (mode_i)
      pio_pkg::SENSE_LOW:  raw_cond = ~level_i;
      pio_pkg::SENSE_HIGH: raw_cond = level_i;
      pio_pkg::SENSE_FALL: raw_cond = prev_q & ~level_i;
      pio_pkg::SENSE_RISE: raw_cond = ~prev_q & level_i;
      default:             raw_cond = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      prev_q <= 1'b0;
    else
      prev_q <= level_i;
  end

  assign cond_o    = enable_i & raw_cond;
  assign edge_mode = (mode_i == pio_pkg::SENSE_FALL) || (mode_i == pio_pkg::SENSE_RISE);
  assign set_o  = cond_o;
  assign clr    = pending_q & (ack_i | ack_seen_q) & ~cond_o;

  // ----------------------------------------------------------------
  // Pending flag
  // ----------------------------------------------------------------
  // Set beats clear, so an event arriving on the acknowledge cycle survives
  // clear on acknowledge
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      pending_q <= 1'b0;
    else if (set_o)
      pending_q <= 1'b1;
    else if (clr)
      pending_q <= 1'b0;
  end

  // An acknowledge given while the cause lingers is remembered until it goes
  // Only a fresh edge voids it; a held level is one long event, not a new one
  // zero writes ignored
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      ack_seen_q <= 1'b0;
    else if (clr || (set_o && edge_mode))
      ack_seen_q <= 1'b0;
    else if (ack_i && pending_q)
      ack_seen_q <= 1'b1;
  end

  assign pending_o  = pending_q;
  assign ack_seen_o = ack_seen_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_RISE_SETS: assert property (@(posedge clock_i) disable iff (rst_i)
    (enable_i && mode_i == pio_pkg::SENSE_RISE && !prev_q && level_i) |=> pending_o)
    else $error("Rising edge did not set pending");

  AST_EDGE_ONCE: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode_i == pio_pkg::SENSE_RISE && $stable(mode_i) && level_i && $past(level_i)) |-> !cond_o)
    else $error("Steady high seen as a rising edge");

endmodule

// ---- testbench/pio_pin_world.sv ----
// Outside world of the 24 channels: open-collector output modules and input sources
`timescale 1ns/1ps
module pio_pin_world
(
  input  wire logic [23:0] drive_i,
  input  wire logic [23:0] oe_i,
  output logic      [23:0] level_o
);
  // A sinking output module wins; a released channel shows its source level
  assign level_o = drive_i & ~oe_i;
endmodule

// ---- testbench/pio24_port_interrupt_logic_tb_top.sv ----
// Self-checking bench for the three ports and their interrupt sources
`timescale 1ns/1ps
module pio24_port_interrupt_logic_tb_top;
  logic        clock_i;
  logic        rst_i;
  logic [2:0]  addr_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  wdata_i;
  logic [7:0]  rdata_o;
  logic [23:0] pin_in_i;
  logic [23:0] pin_out_o;
  logic [23:0] pin_oe_o;
  logic [23:0] src_q;
  logic        ext_irq_i;
  logic        irq_o;
  logic [7:0]  rd_q;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;

  pio_port_irq pio_port_irq_inst
  (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .addr_i    (addr_i),
    .wr_i      (wr_i),
    .rd_i      (rd_i),
    .wdata_i   (wdata_i),
    .rdata_o   (rdata_o),
    .pin_in_i  (pin_in_i),
    .pin_out_o (pin_out_o),
    .pin_oe_o  (pin_oe_o),
    .ext_irq_i (ext_irq_i),
    .irq_o     (irq_o)
  );

  pio_pin_world pio_pin_world_inst
  (
    .drive_i (src_q),
    .oe_i    (pin_oe_o),
    .level_o (pin_in_i)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  // Read data is taken just after the edge that accepted the strobe
  task automatic bus_rd(input logic [2:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    rd_q = rdata_o;
  endtask

  task automatic set_src(input logic [23:0] d, input logic e);
    @(posedge clock_i);
    src_q     <= d;
    ext_irq_i <= e;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [2:0] ofs [6];
    ofs = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    check(pin_out_o, 24'h000000);
    check(pin_oe_o, 24'hFFFFFF);
    check(irq_o, 1'b0);
    foreach (ofs[i])
    begin
      bus_rd(ofs[i]);
      check(rd_q, 8'h00);
    end
  endtask

  task automatic t_ports;
    bus_wr(3'h0, 8'h55);
    bus_wr(3'h1, 8'h5F);
    bus_wr(3'h2, 8'hFF);
    bus_wr(3'h3, 8'hFF);
    set_src(24'hFE_A3_FF, 1'b1);
    tick(4);
    check(pin_out_o, 24'hFF_5F_55);
    check(pin_oe_o, 24'h00_A0_AA);
    bus_rd(3'h0);
    check(rd_q, 8'h55);
    bus_rd(3'h1);
    check(rd_q, 8'h03);
    bus_rd(3'h2);
    check(rd_q, 8'hFE);
    bus_rd(3'h3);
    check(rd_q, 8'h00);
  endtask

  // Level source acknowledged while its cause is still present
  task automatic t_level;
    bus_wr(3'h5, 8'h01);
    bus_wr(3'h6, 8'h01);
    set_src(24'hFF_A3_FF, 1'b1);
    tick(5);
    bus_rd(3'h7);
    check(rd_q, 8'h01);
    check(irq_o, 1'b1);
    bus_wr(3'h7, 8'h00);
    bus_rd(3'h7);
    check(rd_q, 8'h01);
    bus_wr(3'h7, 8'h01);
    tick(3);
    bus_rd(3'h7);
    check(rd_q, 8'h01);
    check(irq_o, 1'b1);
    set_src(24'hFE_A3_FF, 1'b1);
    tick(5);
    bus_rd(3'h7);
    check(rd_q, 8'h00);
    check(irq_o, 1'b0);
  endtask

  // Every sense encoding on both port C nibbles and the external source
  task automatic t_modes;
    logic       idle;
    logic [5:0] sel;
    for (int m = 0; m < 4; m++)
    begin
      idle = ~m[0];
      sel  = {m[1:0], m[1:0], m[1:0]};
      // Sources disabled while the pins move to their idle level
      bus_wr(3'h5, 8'h00);
      bus_wr(3'h6, {2'b00, sel});
      set_src({{8{idle}}, 16'hA3FF}, idle);
      tick(4);
      bus_wr(3'h7, 8'hFF);
      bus_wr(3'h6, {2'b10, sel});
      bus_wr(3'h5, 8'h82);
      bus_wr(3'h6, {2'b01, sel});
      set_src({{8{~idle}}, 16'hA3FF}, ~idle);
      tick(5);
      bus_rd(3'h7);
      check(rd_q, 8'h82);
      bus_rd(3'h6);
      check(rd_q, {2'b11, sel});
      check(irq_o, 1'b1);
      set_src({{8{idle}}, 16'hA3FF}, idle);
      tick(5);
      bus_wr(3'h7, 8'h80);
      tick(3);
      bus_rd(3'h7);
      check(rd_q, 8'h02);
      check(irq_o, 1'b1);
      bus_wr(3'h7, 8'h02);
      bus_wr(3'h6, {2'b11, sel});
      tick(3);
      bus_rd(3'h7);
      check(rd_q, 8'h00);
      bus_rd(3'h6);
      check(rd_q, {2'b01, sel});
      check(irq_o, 1'b0);
    end
  endtask

  // Reset in mid-run with a live pending source and programmed latches
  task automatic t_midreset;
    bus_wr(3'h5, 8'h01);
    bus_wr(3'h6, 8'h01);
    set_src(24'hFFFFFF, 1'b1);
    tick(5);
    check(irq_o, 1'b1);
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    tick(1);
    check(pin_out_o, 24'h000000);
    check(pin_oe_o, 24'hFFFFFF);
    check(irq_o, 1'b0);
    bus_rd(3'h7);
    check(rd_q, 8'h00);
    bus_rd(3'h6);
    check(rd_q, 8'h00);
    bus_rd(3'h5);
    check(rd_q, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures++;
      report_and_stop;
    end
  end

  initial
  begin
    rst_i     = 1'b1;
    addr_i    = 3'h0;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    wdata_i   = 8'h00;
    src_q     = 24'hFFFFFF;
    ext_irq_i = 1'b1;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    tick(1);
    t_reset;
    t_ports;
    t_level;
    t_modes;
    t_midreset;
    report_and_stop;
  end
endmodule
